// file: core/fpec_pkg.sv
// Package for the flash command sequencer: register map, command codes, field layout, timing.
// Assumes a single 125 MHz clock domain and an AHB-Lite register bus.
package fpec_pkg;
    // Register byte offsets
    localparam logic [7:0] FPEC_OFF_STATUS = 8'h00;
    localparam logic [7:0] FPEC_OFF_INDEX = 8'h04;
    localparam logic [7:0] FPEC_OFF_CMDWORD = 8'h08;
    localparam logic [7:0] FPEC_OFF_CONFIG = 8'h0C;
    localparam logic [7:0] FPEC_OFF_OTPSTAT = 8'h10;
    // Status word bit positions
    localparam int FPEC_ST_CCF = 7;
    localparam int FPEC_ST_ACC = 5;
    localparam int FPEC_ST_PVIOL = 4;
    localparam int FPEC_ST_VERR = 1;
    localparam int FPEC_ST_UVERR = 0;
    // Config register bit positions
    localparam int FPEC_CFG_MODE_OK = 0;
    localparam int FPEC_CFG_PPROT = 1;
    localparam int FPEC_CFG_DPROT = 2;
    localparam int FPEC_CFG_INJ_ERR = 3;
    localparam int FPEC_CFG_INJ_UNC = 4;
    localparam int FPEC_CFG_SECURE = 8;
    localparam logic [31:0] FPEC_CFG_RESET = 32'h0000_0101;
    // Protected window of program flash: addresses at or above this bound
    localparam logic [17:0] FPEC_PROT_BASE = 18'h3_8000;
    // Command codes
    localparam logic [7:0] FPEC_CMD_PROG = 8'h06;
    localparam logic [7:0] FPEC_CMD_OTP = 8'h07;
    localparam logic [7:0] FPEC_CMD_ERALL = 8'h08;
    localparam logic [7:0] FPEC_CMD_ERBLK = 8'h09;
    // Needed final word index per command
    localparam logic [2:0] FPEC_IX_PROG = 3'h5;
    localparam logic [2:0] FPEC_IX_ERALL = 3'h0;
    localparam logic [2:0] FPEC_IX_ERBLK = 3'h1;
    localparam logic [15:0] FPEC_OTP_LAST = 16'h0007;
    // Block select values: 2'b11 program flash, 2'b00 data flash
    localparam logic [1:0] FPEC_BLK_PF = 2'h3;
    localparam logic [1:0] FPEC_BLK_DF = 2'h0;
    // Embedded algorithm step times in ns
    localparam int FPEC_T_PROG_NS = 20000;
    localparam int FPEC_T_ERASE_NS = 100000;
    localparam int FPEC_T_VERIFY_NS = 1000;
    localparam int FPEC_CLK_MHZ = 125;
    localparam int FPEC_PROG_CYC = (FPEC_T_PROG_NS * FPEC_CLK_MHZ + 999) / 1000;
    localparam int FPEC_ERASE_CYC = (FPEC_T_ERASE_NS * FPEC_CLK_MHZ + 999) / 1000;
    localparam int FPEC_VERIFY_CYC = (FPEC_T_VERIFY_NS * FPEC_CLK_MHZ + 999) / 1000;
    typedef enum logic [5:0] {
        FPEC_IDLE = 6'b000001,
        FPEC_BLANK = 6'b000010,
        FPEC_PROG = 6'b000100,
        FPEC_ERASE = 6'b001000,
        FPEC_VERIFY = 6'b010000,
        FPEC_DONE = 6'b100000
    } fpec_state_t;
endpackage : fpec_pkg

// file: core/fpec_sequencer.sv
// Flash program/erase command sequencer with AHB-Lite register slave.
// Assumes hclk at 125 MHz; the flash array itself is modelled by timed steps
// and an OTP shadow, so verify faults come from the config inject bits.
// Function
// [R1] Phrase program: code 0x06 with block bits, address, four data words at 2..5.
// [R2] Software gives phrase-aligned address; misaligned address raises access error.
// [R3] Program writes four words, reads back, sets complete flag at end.
// [R4] Phrase program access error on index not 5, mode, or bad address.
// [R5] Phrase program into protected area raises protection flag, no write.
// [R6] Verify step sets error flag and uncorrectable flag on faults.
// [R7] OTP program: code 0x07, phrase index 0..7, four data words.
// [R8] OTP checks phrase erased, then programs and verifies; complete clear meanwhile.
// [R9] OTP on already programmed phrase raises access error, no write.
// [R10] OTP phrase left all ones still counts as unprogrammed.
// [R11] OTP access error for index above 7 or word index not 5.
// [R12] During OTP, program flash reads return invalid data, no stall.
// [R13] Erase all: code 0x08 alone; access error if index not 0 or mode.
// [R14] Erase all erases, verifies, releases security only on clean verify.
// [R15] Erase all with any protection raises protection flag, no erase.
// [R16] Software writes no register while erase all runs.
// [R17] Block erase: code 0x09, block bits, address; access error if index not 1.
// [R18] Block erase erases selected block, verifies, then sets complete flag.
// [R19] Block erase access error on misaligned program or data flash address.
// [R20] Block erase access error for unknown block or disallowed mode.
// [R21] Block erase with protected block raises protection flag, no erase.
// [R22] Software issues OTP once per phrase, not from the OTP block.
// [R23] A launch error skips the algorithm and sets complete flag at once.
module fpec_sequencer
    import fpec_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Program flash read port
    input wire logic pf_rd_req,
    output logic pf_rd_invalid,
    // Status
    output logic security_released,
    output logic busy
);
    import fpec_pkg::*;

    // Bus address phase capture
    logic wr_pend_q, wr_pend_d;
    logic [7:0] wa_q, wa_d;
    logic [31:0] rdata_q, rdata_d;
    // Command object and status
    logic [2:0] command_word_index_q, command_word_index_d;
    logic [15:0] command_object_word_q [0:5];
    logic [15:0] command_object_word_d [0:5];
    logic command_complete_flag_q, command_complete_flag_d;
    logic access_error_flag_q, access_error_flag_d;
    logic protection_violation_flag_q, protection_violation_flag_d;
    logic verify_error_flag_q, verify_error_flag_d;
    logic uncorrectable_verify_flag_q, uncorrectable_verify_flag_d;
    logic [31:0] cfg_q, cfg_d;
    logic [7:0] otp_used_q, otp_used_d;
    logic [63:0] otp_data_q [0:7];
    logic [63:0] otp_data_d [0:7];
    // Sequencer
    fpec_state_t state_q, state_d;
    logic [7:0] cmd_q, cmd_d;
    logic [13:0] cnt_q, cnt_d;
    logic [2:0] otp_ix_q, otp_ix_d;
    logic pf_inv_q, pf_inv_d;
    logic busy_q, busy_d;
    // Output registers
    logic hreadyout_q, hreadyout_d;
    logic hresp_q, hresp_d;
    logic sec_rel_q, sec_rel_d;

    logic [31:0] flash_status_word;
    logic take, launch, acc, prot;
    logic [17:0] gaddr;
    logic [63:0] phrase;
    logic [7:0] cmd_code;
    logic [2:0] otp_sel;
    logic blk_pf, blk_df, phrase_aligned;

    assign take = hsel && hready && htrans[1];
    assign flash_status_word = {24'h0, command_complete_flag_q, 1'b0, access_error_flag_q,
        protection_violation_flag_q, 2'b00, verify_error_flag_q, uncorrectable_verify_flag_q};
    assign gaddr = {command_object_word_q[0][1:0], command_object_word_q[1]};
    assign phrase = {command_object_word_q[2], command_object_word_q[3],
        command_object_word_q[4], command_object_word_q[5]};
    assign cmd_code = command_object_word_q[0][15:8];
    assign otp_sel = command_object_word_q[1][2:0];
    // Shared address decode for the launch checks
    assign blk_pf = (gaddr[17:16] == FPEC_BLK_PF);
    assign blk_df = (gaddr[17:16] == FPEC_BLK_DF);
    assign phrase_aligned = (gaddr[2:0] == 3'h0);
    // Launch is taken in the write data phase and only while the complete flag reads one
    assign launch = wr_pend_q && (wa_q == FPEC_OFF_STATUS) && hwdata[FPEC_ST_CCF]
        && command_complete_flag_q;

    // Launch checks, evaluated against the command object as it stands
    always_comb
    begin
        acc = 1'b0;
        prot = 1'b0;
        case (cmd_code)
            FPEC_CMD_PROG:
            begin
                acc = (command_word_index_q != FPEC_IX_PROG) || !cfg_q[FPEC_CFG_MODE_OK] // R4
                    || !blk_pf || !phrase_aligned; // R2 R4
                prot = cfg_q[FPEC_CFG_PPROT] && (gaddr >= FPEC_PROT_BASE); // R5
            end
            FPEC_CMD_OTP:
            begin
                acc = (command_word_index_q != FPEC_IX_PROG) || !cfg_q[FPEC_CFG_MODE_OK]
                    || (command_object_word_q[1] > FPEC_OTP_LAST); // R11
                // Used phrase is refused unless it holds all ones
                if (!acc)
                    acc = otp_used_q[otp_sel]
                        && (otp_data_q[otp_sel] != 64'hFFFF_FFFF_FFFF_FFFF); // R9 R10
            end
            FPEC_CMD_ERALL:
            begin
                acc = (command_word_index_q != FPEC_IX_ERALL) || !cfg_q[FPEC_CFG_MODE_OK]; // R13
                prot = cfg_q[FPEC_CFG_PPROT] || cfg_q[FPEC_CFG_DPROT]; // R15
            end
            FPEC_CMD_ERBLK:
            begin
                acc = (command_word_index_q != FPEC_IX_ERBLK) || !cfg_q[FPEC_CFG_MODE_OK] // R17 R20
                    || !(blk_pf || blk_df) // R20
                    || (blk_pf && !phrase_aligned) // R19
                    || (blk_df && gaddr[0]); // R19
                prot = blk_pf ? cfg_q[FPEC_CFG_PPROT] : cfg_q[FPEC_CFG_DPROT]; // R21
            end
            default: acc = 1'b1;
        endcase
    end

    // Bus and register next state
    always_comb
    begin
        wr_pend_d = take && hwrite;
        wa_d = take ? haddr[7:0] : wa_q;
        rdata_d = rdata_q;
        command_word_index_d = command_word_index_q;
        command_object_word_d = command_object_word_q;
        cfg_d = cfg_q;
        if (take && !hwrite)
        begin
            case (haddr[7:0])
                FPEC_OFF_STATUS: rdata_d = flash_status_word;
                FPEC_OFF_INDEX: rdata_d = {29'h0, command_word_index_q};
                FPEC_OFF_CMDWORD: rdata_d = (command_word_index_q <= 3'h5)
                    ? {16'h0, command_object_word_q[command_word_index_q]} : 32'h0;
                FPEC_OFF_CONFIG: rdata_d = cfg_q;
                FPEC_OFF_OTPSTAT: rdata_d = {24'h0, otp_used_q};
                default: rdata_d = 32'h0;
            endcase
        end
        // Writes are ignored while a command runs
        if (wr_pend_q && command_complete_flag_q)
        begin
            case (wa_q)
                FPEC_OFF_INDEX: command_word_index_d = hwdata[2:0];
                FPEC_OFF_CMDWORD:
                    if (command_word_index_q <= 3'h5)
                        command_object_word_d[command_word_index_q] = hwdata[15:0]; // R1 R7
                // Secure bit is read-only: only a clean erase-all clears it
                FPEC_OFF_CONFIG: cfg_d = {cfg_q[31:8], hwdata[7:0]};
                default: ;
            endcase
        end
        // A failed verify leaves the security state untouched
        if (state_q == FPEC_DONE && cmd_q == FPEC_CMD_ERALL && !verify_error_flag_q)
            cfg_d[FPEC_CFG_SECURE] = 1'b0; // R14
    end

    // Sequencer next state
    always_comb
    begin
        state_d = state_q;
        cmd_d = cmd_q;
        cnt_d = cnt_q;
        otp_ix_d = otp_ix_q;
        otp_used_d = otp_used_q;
        otp_data_d = otp_data_q;
        command_complete_flag_d = command_complete_flag_q;
        access_error_flag_d = access_error_flag_q;
        protection_violation_flag_d = protection_violation_flag_q;
        verify_error_flag_d = verify_error_flag_q;
        uncorrectable_verify_flag_d = uncorrectable_verify_flag_q;
        // Write-one-to-clear of the access and protection error flags
        if (wr_pend_q && wa_q == FPEC_OFF_STATUS && command_complete_flag_q)
        begin
            if (hwdata[FPEC_ST_ACC])
                access_error_flag_d = 1'b0;
            if (hwdata[FPEC_ST_PVIOL])
                protection_violation_flag_d = 1'b0;
        end
        case (state_q)
            FPEC_IDLE:
                // Launch refused while a launch error is still pending
                if (launch && !access_error_flag_q && !protection_violation_flag_q)
                begin
                    verify_error_flag_d = 1'b0;
                    uncorrectable_verify_flag_d = 1'b0;
                    // Access error hides protection so software sees a single cause
                    if (acc || prot) // R23
                    begin
                        access_error_flag_d = acc;
                        protection_violation_flag_d = prot && !acc;
                    end
                    else
                    begin
                        command_complete_flag_d = 1'b0; // R3 R8
                        cmd_d = cmd_code;
                        otp_ix_d = otp_sel;
                        cnt_d = 14'h0;
                        case (cmd_code)
                            FPEC_CMD_OTP: state_d = FPEC_BLANK; // R8
                            FPEC_CMD_PROG: state_d = FPEC_PROG;
                            default: state_d = FPEC_ERASE; // R14 R18
                        endcase
                    end
                end
            FPEC_BLANK:
            begin
                // Erased state was checked at launch; this step models the blank read time
                cnt_d = cnt_q + 14'h1;
                if (cnt_q == 14'(FPEC_VERIFY_CYC - 1))
                begin
                    cnt_d = 14'h0;
                    state_d = FPEC_PROG;
                end
            end
            FPEC_PROG:
            begin
                cnt_d = cnt_q + 14'h1;
                if (cnt_q == 14'(FPEC_PROG_CYC - 1))
                begin
                    cnt_d = 14'h0;
                    state_d = FPEC_VERIFY; // R3
                    if (cmd_q == FPEC_CMD_OTP)
                    begin
                        otp_used_d[otp_ix_q] = 1'b1;
                        otp_data_d[otp_ix_q] = phrase;
                    end
                end
            end
            FPEC_ERASE:
            begin
                cnt_d = cnt_q + 14'h1;
                if (cnt_q == 14'(FPEC_ERASE_CYC - 1))
                begin
                    cnt_d = 14'h0;
                    state_d = FPEC_VERIFY;
                end
            end
            FPEC_VERIFY:
            begin
                cnt_d = cnt_q + 14'h1;
                if (cnt_q == 14'(FPEC_VERIFY_CYC - 1))
                begin
                    verify_error_flag_d = cfg_q[FPEC_CFG_INJ_ERR] || cfg_q[FPEC_CFG_INJ_UNC]; // R6
                    uncorrectable_verify_flag_d = cfg_q[FPEC_CFG_INJ_UNC]; // R6
                    state_d = FPEC_DONE;
                end
            end
            FPEC_DONE:
            begin
                command_complete_flag_d = 1'b1; // R3 R18
                state_d = FPEC_IDLE;
            end
            default: state_d = FPEC_IDLE;
        endcase
        // Reads are answered at once but flagged while an OTP command owns the array
        pf_inv_d = (state_d != FPEC_IDLE) && (cmd_d == FPEC_CMD_OTP) && pf_rd_req; // R12
        busy_d = (state_d != FPEC_IDLE);
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            wa_q <= 8'h00;
            rdata_q <= 32'h0;
            command_word_index_q <= 3'h0;
            for (int i = 0; i < 6; i++)
                command_object_word_q[i] <= 16'h0;
            cfg_q <= FPEC_CFG_RESET;
        end
        else
        begin
            wr_pend_q <= wr_pend_d;
            wa_q <= wa_d;
            rdata_q <= rdata_d;
            command_word_index_q <= command_word_index_d;
            command_object_word_q <= command_object_word_d;
            cfg_q <= cfg_d;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_q <= FPEC_IDLE;
            cmd_q <= 8'h00;
            cnt_q <= 14'h0;
            otp_ix_q <= 3'h0;
            otp_used_q <= 8'h00;
            for (int i = 0; i < 8; i++)
                otp_data_q[i] <= 64'hFFFF_FFFF_FFFF_FFFF;
            command_complete_flag_q <= 1'b1;
            access_error_flag_q <= 1'b0;
            protection_violation_flag_q <= 1'b0;
            verify_error_flag_q <= 1'b0;
            uncorrectable_verify_flag_q <= 1'b0;
            pf_inv_q <= 1'b0;
            busy_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cmd_q <= cmd_d;
            cnt_q <= cnt_d;
            otp_ix_q <= otp_ix_d;
            otp_used_q <= otp_used_d;
            otp_data_q <= otp_data_d;
            command_complete_flag_q <= command_complete_flag_d;
            access_error_flag_q <= access_error_flag_d;
            protection_violation_flag_q <= protection_violation_flag_d;
            verify_error_flag_q <= verify_error_flag_d;
            uncorrectable_verify_flag_q <= uncorrectable_verify_flag_d;
            pf_inv_q <= pf_inv_d;
            busy_q <= busy_d;
        end
    end

    // Bus answer and security outputs kept in flops so every port leaves a register
    always_comb
    begin
        hreadyout_d = 1'b1;
        hresp_d = 1'b0;
        sec_rel_d = ~cfg_d[FPEC_CFG_SECURE]; // R14
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
            sec_rel_q <= ~FPEC_CFG_RESET[FPEC_CFG_SECURE];
        end
        else
        begin
            hreadyout_q <= hreadyout_d;
            hresp_q <= hresp_d;
            sec_rel_q <= sec_rel_d;
        end
    end

    assign hrdata = rdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp = hresp_q;
    assign pf_rd_invalid = pf_inv_q;
    assign security_released = sec_rel_q;
    assign busy = busy_q;
endmodule : fpec_sequencer

// file: bench/fpec_sequencer_checker.sv
// Checker for the flash command sequencer: bus answer, busy span, read invalid flag, security.
// Assumes it is bound to fpec_sequencer and sees only its ports.
module fpec_sequencer_checker
    import fpec_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Flash read port and status
    input wire logic pf_rd_req,
    input wire logic pf_rd_invalid,
    input wire logic security_released,
    input wire logic busy
);
    // Shortest run is a program, longest an erase; both include verify
    localparam int MIN_BUSY = FPEC_PROG_CYC + FPEC_VERIFY_CYC;
    localparam int MAX_BUSY = FPEC_ERASE_CYC + FPEC_VERIFY_CYC + 1;
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic rd_take;
    assign rd_take = hsel && hready && htrans[1] && !hwrite;
    always_comb
    begin
        cnt_d = busy ? cnt_q + 16'h1 : 16'h0;
    end
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            cnt_q <= 16'h0;
        else
            cnt_q <= cnt_d;
    end
    default clocking dc @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    AST_NO_STALL: assert property (hreadyout && !hresp)
        else $error("slave stalled or answered with an error");
    AST_HRDATA_HOLD: assert property (!rd_take |=> $stable(hrdata))
        else $error("read data changed without a read");
    AST_STATUS_CCF: assert property (rd_take && haddr[7:0] == FPEC_OFF_STATUS
        |=> hrdata[FPEC_ST_CCF] == !$past(busy))
        else $error("complete flag disagrees with busy");
    AST_PFINV_CAUSE: assert property (pf_rd_invalid |-> $past(pf_rd_req) && $past(busy))
        else $error("invalid read flag without a read during a command");
    AST_SEC_RISE: assert property ($rose(security_released) |-> $past(busy, 2))
        else $error("security released outside an erase");
    AST_SEC_STICKY: assert property (!$fell(security_released))
        else $error("security state fell back");
    AST_BUSY_MIN: assert property ($fell(busy) |-> cnt_q >= MIN_BUSY)
        else $error("command finished too early");
    AST_BUSY_MAX: assert property (busy |-> cnt_q <= MAX_BUSY)
        else $error("command ran too long");
    COV_DONE: cover property ($fell(busy));
    COV_SEC: cover property ($rose(security_released));
    COV_PFINV: cover property (pf_rd_invalid);
endmodule : fpec_sequencer_checker

bind fpec_sequencer fpec_sequencer_checker i_fpec_sequencer_checker (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pf_rd_req(pf_rd_req),
    .pf_rd_invalid(pf_rd_invalid), .security_released(security_released), .busy(busy)
);

// file: bench/fpec_sequencer_tb.sv
// Self-checking bench for the flash command sequencer over AHB-Lite.
// Assumes the step times of fpec_pkg; the bench is the only bus master.
module fpec_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import fpec_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic pf_rd_req = 1'b0;
    wire logic hready;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic pf_rd_invalid;
    logic security_released;
    logic busy;
    logic [31:0] rd;
    int bad_count = 0;
    int checks_done = 0;
    always #4 hclk = ~hclk;
    assign hready = hreadyout;
    fpec_sequencer i_fpec_sequencer (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .pf_rd_req(pf_rd_req),
        .pf_rd_invalid(pf_rd_invalid), .security_released(security_released), .busy(busy)
    );
    task automatic end_of_test();
        if (bad_count == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Called right after a rising edge; returns at the edge ending the data phase
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hready !== 1'b1)
            @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1)
            @(posedge hclk);
        q = hrdata;
    endtask : xfer
    // Loads words 0..ix, launches, checks the early state, then polls to completion
    task automatic run(input logic [2:0] ix, input logic [15:0] w0, input logic [15:0] w1,
                       input logic [7:0] cfg, input logic [15:0] d, input logic [7:0] exp);
        logic [31:0] q;
        int n;
        xfer(1'b1, FPEC_OFF_CONFIG, {24'h0, cfg}, q);
        xfer(1'b1, FPEC_OFF_STATUS, 32'h0000_0030, q);
        for (int i = 0; i <= int'(ix); i++)
        begin
            xfer(1'b1, FPEC_OFF_INDEX, 32'(i), q);
            xfer(1'b1, FPEC_OFF_CMDWORD, {16'h0, (i == 0) ? w0 : (i == 1) ? w1 : d}, q);
        end
        xfer(1'b1, FPEC_OFF_STATUS, 32'h0000_0080, q);
        pf_rd_req <= 1'b1;
        repeat (2) @(posedge hclk);
        chk("busy", {31'h0, exp[5:4] == 2'h0}, {31'h0, busy});
        chk("pf_rd_invalid", {31'h0, w0[15:8] == 8'h07 && exp[5:4] == 2'h0},
            {31'h0, pf_rd_invalid});
        n = 0;
        q = 32'h0;
        while (q[FPEC_ST_CCF] !== 1'b1 && n < 20000)
        begin
            xfer(1'b0, FPEC_OFF_STATUS, 32'h0, q);
            n++;
        end
        pf_rd_req <= 1'b0;
        chk("status", {24'h0, exp}, q & 32'h0000_00B3);
    endtask : run
    initial
    begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        xfer(1'b0, FPEC_OFF_STATUS, 32'h0, rd);
        chk("status at reset", 32'h0000_0080, rd & 32'h0000_00B3);
        xfer(1'b0, FPEC_OFF_CONFIG, 32'h0, rd);
        chk("config at reset", FPEC_CFG_RESET, rd);
        xfer(1'b1, 8'h14, 32'hFFFF_FFFF, rd);
        xfer(1'b0, 8'h14, 32'h0, rd);
        chk("unmapped", 32'h0, rd);
        run(3'h5, 16'h0603, 16'h0000, 8'h01, 16'h5A5A, 8'h80);
        xfer(1'b0, FPEC_OFF_INDEX, 32'h0, rd);
        chk("index", 32'h0000_0005, rd);
        xfer(1'b0, FPEC_OFF_CMDWORD, 32'h0, rd);
        chk("command word", 32'h0000_5A5A, rd);
        run(3'h4, 16'h0603, 16'h0008, 8'h01, 16'h5A5A, 8'hA0);
        run(3'h5, 16'h0603, 16'h0004, 8'h01, 16'h5A5A, 8'hA0);
        run(3'h5, 16'h0601, 16'h0008, 8'h01, 16'h5A5A, 8'hA0);
        run(3'h5, 16'h0603, 16'h0008, 8'h00, 16'h5A5A, 8'hA0);
        run(3'h5, 16'h0603, 16'h8000, 8'h03, 16'h5A5A, 8'h90);
        run(3'h5, 16'h0603, 16'h0010, 8'h09, 16'h5A5A, 8'h82);
        run(3'h5, 16'h0603, 16'h0018, 8'h11, 16'h5A5A, 8'h83);
        run(3'h5, 16'h0700, 16'h0008, 8'h01, 16'h1234, 8'hA0);
        run(3'h4, 16'h0700, 16'h0000, 8'h01, 16'h1234, 8'hA0);
        run(3'h5, 16'h0700, 16'h0000, 8'h01, 16'h1234, 8'h80);
        run(3'h5, 16'h0700, 16'h0000, 8'h01, 16'h1234, 8'hA0);
        run(3'h5, 16'h0700, 16'h0001, 8'h01, 16'hFFFF, 8'h80);
        run(3'h5, 16'h0700, 16'h0001, 8'h01, 16'hFFFF, 8'h80);
        xfer(1'b0, FPEC_OFF_OTPSTAT, 32'h0, rd);
        chk("used phrases", 32'h0000_0003, rd);
        run(3'h1, 16'h0903, 16'h0004, 8'h01, 16'h0000, 8'hA0);
        run(3'h1, 16'h0900, 16'h0001, 8'h01, 16'h0000, 8'hA0);
        run(3'h1, 16'h0902, 16'h0000, 8'h01, 16'h0000, 8'hA0);
        run(3'h1, 16'h0900, 16'h0000, 8'h00, 16'h0000, 8'hA0);
        run(3'h5, 16'h0900, 16'h0000, 8'h01, 16'h0000, 8'hA0);
        run(3'h1, 16'h0900, 16'h0000, 8'h05, 16'h0000, 8'h90);
        run(3'h1, 16'h0900, 16'h0000, 8'h01, 16'h0000, 8'h80);
        run(3'h1, 16'h0800, 16'h0000, 8'h01, 16'h0000, 8'hA0);
        run(3'h0, 16'h0800, 16'h0000, 8'h00, 16'h0000, 8'hA0);
        run(3'h0, 16'h0800, 16'h0000, 8'h05, 16'h0000, 8'h90);
        run(3'h0, 16'h0800, 16'h0000, 8'h09, 16'h0000, 8'h82);
        chk("security kept", 32'h0, {31'h0, security_released});
        run(3'h0, 16'h0800, 16'h0000, 8'h01, 16'h0000, 8'h80);
        chk("security released", 32'h1, {31'h0, security_released});
        end_of_test();
    end
    // About 55000 cycles are expected; this bound leaves margin
    initial
    begin
        #(8 * 100000);
        bad_count++;
        end_of_test();
    end
endmodule : fpec_sequencer_tb
